// *** pkg/fault_status_pkg.sv ***
/*
 * Constants for the fault status and pending-set block: register
 * offsets, field positions, reset values and interrupt status layout.
 * Assumes a plain strobe register port with read data one cycle later.
 */
package fault_status_pkg;
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_PEND_FORCE = 8'h00;
	localparam logic [7:0] OFS_USAGE      = 8'h04;
	localparam logic [7:0] OFS_HARD       = 8'h08;
	localparam logic [7:0] OFS_CONFIG     = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;

	// Usage fault cause fields
	localparam int UF_UNDEF     = 0;
	localparam int UF_STATE     = 1;
	localparam int UF_PC        = 2;
	localparam int UF_NO_COPROC = 3;
	localparam int UF_MISALIGN  = 8;
	localparam int UF_ZERO_DIV  = 9;
	localparam logic [15:0] UF_IMPL_MASK = 16'h030F;

	// Hard fault cause fields
	localparam int HF_VECTOR    = 1;
	localparam int HF_FORCED    = 30;
	localparam int HF_DEBUG     = 31;
	localparam logic [31:0] HF_IMPL_MASK = 32'hC000_0002;

	// Configuration control fields
	localparam int CFG_MISALIGN_TRAP = 3;
	localparam int CFG_ZERO_DIV_TRAP = 4;

	// Interrupt status fields
	localparam int IS_USAGE = 0;
	localparam int IS_HARD  = 1;
	localparam int IS_WIDTH = 2;

	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : fault_status_pkg

// *** src/fault_status_unit.sv ***
/*
 * Fault status and pending-set logic of the exception unit: the
 * interrupt pending-force register, usage and hard fault cause
 * registers, configuration trap enables and a status interrupt.
 * Assumes the execution stage gives one-cycle detect pulses on clock.
 */
// What this block does
// RULE1: Writing 1 to a pending-force bit makes that interrupt pending; 0 does nothing.
// RULE2: Reading pending-force returns 1 for pending interrupts, 0 otherwise.
// RULE3: Writing 1 to pending or disabled interrupts still leaves it pending.
// RULE4: Zero-divisor flag sets on divide by zero only with the trap enabled.
// RULE5: Zero-divisor fault stacks the divide instruction's address.
// RULE6: Misalign flag at bit 8 sets on unaligned access when trap enabled.
// RULE7: Unaligned multiple or double transfers always raise the misalign flag.
// RULE8: Any coprocessor access sets the no-coprocessor flag at bit 3.
// RULE9: Bad exception return sets bit 2 and stacks the offending address.
// RULE10: Illegal execution-status use sets bit 1 and stacks that instruction.
// RULE11: Undefined instructions never set the bad execution-state flag.
// RULE12: Hard fault bits are sticky, cleared by writing 1 or reset.
// RULE13: Software must write 0 to the debug event bit 31.
// RULE14: Forced flag at bit 30 sets on escalation of a configurable fault.
// RULE15: Vector fetch bus error sets bit 1, stacks the preempted address.
// RULE16: Handler reads other fault registers when the forced flag is set.
// RULE17: Undefined opcode flag at bit 0 sets on an undefined instruction.
// RULE18: Usage fault flags stay set until software writes 1 or reset.
`timescale 1ns/1ps
module fault_status_unit
	import fault_status_pkg::*;
#(
	parameter int IRQ_COUNT = 32
) (
	input  wire logic                 clock,
	input  wire logic                 srst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [31:0]          reg_rdata,
	// Interrupt pending state shared with the interrupt controller
	input  wire logic [IRQ_COUNT-1:0] irq_pending_in,
	output logic      [IRQ_COUNT-1:0] pend_set_pulse,
	// Fault detect pulses from execution
	input  wire logic                 exec_valid,
	input  wire logic [31:0]          exec_pc,
	input  wire logic                 divide_op,
	input  wire logic                 divisor_zero,
	input  wire logic                 unaligned_access,
	input  wire logic                 multi_or_double_op,
	input  wire logic                 coproc_access,
	input  wire logic                 undefined_opcode,
	input  wire logic                 exec_status_misuse,
	input  wire logic                 bad_return_load,
	// Exception entry events
	input  wire logic                 escalate_fault,
	input  wire logic                 vector_bus_error,
	input  wire logic [31:0]          preempted_pc,
	// Stacked return address towards the exception entry logic, and the status interrupt
	output logic                      stack_valid,
	output logic      [31:0]          stack_pc,
	output logic                      irq
);

	// Pending-force port is at most one register word wide
	if (IRQ_COUNT < 1 || IRQ_COUNT > 32) begin : g_irq_count_bad
		$error("IRQ_COUNT must lie between 1 and 32");
	end

	// Register state
	logic [IRQ_COUNT-1:0] pend_set_q, pend_set_d;
	// Sticky cause flags and software settings
	logic [15:0]          usage_q, usage_d;
	logic [31:0]          hard_q, hard_d;
	logic [31:0]          config_q, config_d;
	logic [IS_WIDTH-1:0]  istat_q, istat_d;
	logic [IS_WIDTH-1:0]  imask_q, imask_d;
	// Output stage: read data, stacked address, interrupt
	logic [31:0]          rdata_q, rdata_d;
	logic                 stack_valid_q, stack_valid_d;
	logic [31:0]          stack_pc_q, stack_pc_d;
	logic                 irq_q, irq_d;

	// Decoded fault events and register access strobes
	logic [15:0] uf_set;
	logic [31:0] hf_set;
	logic        wr_pend, wr_usage, wr_hard, wr_cfg, wr_mask;
	logic        rd_stat;

	// Address match, shared by the write and read decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Fault detection; an undefined opcode masks the execution-state fault
	always_comb begin
		uf_set = 16'h0000;
		hf_set = 32'h0000_0000;
		// Execution faults count only for an instruction really executing
		if (exec_valid) begin
			// Trap enables come from the registered configuration word
			uf_set[UF_ZERO_DIV] = divide_op & divisor_zero
				& config_q[CFG_ZERO_DIV_TRAP]; // RULE4
			uf_set[UF_MISALIGN] = unaligned_access
				& (config_q[CFG_MISALIGN_TRAP] | multi_or_double_op); // RULE6 RULE7
			uf_set[UF_NO_COPROC] = coproc_access; // RULE8
			uf_set[UF_PC]    = bad_return_load; // RULE9
			uf_set[UF_STATE] = exec_status_misuse & ~undefined_opcode; // RULE10 RULE11
			uf_set[UF_UNDEF] = undefined_opcode; // RULE17
		end
		// Entry events arrive without an executing instruction
		hf_set[HF_FORCED] = escalate_fault; // RULE14
		hf_set[HF_VECTOR] = vector_bus_error; // RULE15
	end

	// Write and read decode
	always_comb begin
		wr_pend  = reg_write & hit(reg_addr, OFS_PEND_FORCE);
		wr_usage = reg_write & hit(reg_addr, OFS_USAGE);
		wr_hard  = reg_write & hit(reg_addr, OFS_HARD);
		wr_cfg   = reg_write & hit(reg_addr, OFS_CONFIG);
		wr_mask  = reg_write & hit(reg_addr, OFS_IRQ_MASK);
		// Status clears on its read strobe, never on a write
		rd_stat  = reg_read & hit(reg_addr, OFS_IRQ_STAT);
	end

	// Next register state; hardware set wins over a same-cycle clear
	always_comb begin
		// Pulse only; the pending state itself lives in the controller
		pend_set_d = '0;
		if (wr_pend) begin
			pend_set_d = reg_wdata[IRQ_COUNT-1:0]; // RULE1 RULE3
		end
		// Clear by a write of 1 first, then new faults OR in so a set wins
		usage_d = usage_q;
		if (wr_usage) begin
			usage_d = usage_q & ~reg_wdata[15:0]; // RULE18
		end
		usage_d = (usage_d | uf_set) & UF_IMPL_MASK; // RULE18
		// Same sticky scheme; unimplemented bits never hold a 1
		hard_d = hard_q;
		if (wr_hard) begin
			// Debug bit is cleared only; software keeps it 0 on writes
			hard_d = hard_q & ~reg_wdata; // RULE12 RULE13
		end
		hard_d = (hard_d | hf_set) & HF_IMPL_MASK; // RULE12
		// Only the two trap enables are kept; other bits read zero
		config_d = config_q;
		if (wr_cfg) begin
			config_d = RST_ZERO;
			config_d[CFG_MISALIGN_TRAP] = reg_wdata[CFG_MISALIGN_TRAP];
			config_d[CFG_ZERO_DIV_TRAP] = reg_wdata[CFG_ZERO_DIV_TRAP];
		end
		imask_d = wr_mask ? reg_wdata[IS_WIDTH-1:0] : imask_q;
		// Status sticks until read; an event in the read cycle survives
		istat_d = rd_stat ? '0 : istat_q;
		istat_d[IS_USAGE] = istat_d[IS_USAGE] | (|uf_set);
		istat_d[IS_HARD]  = istat_d[IS_HARD] | (|hf_set);
		// Built from next state so the line moves with the status bits
		irq_d = |(istat_d & imask_d);
	end

	// Stacked return address: faulting or preempted instruction
	always_comb begin
		stack_valid_d = 1'b0;
		// Address held between faults for the entry logic to pick up
		stack_pc_d    = stack_pc_q;
		// Usage faults win over a vector error in the same cycle
		if (|uf_set) begin
			stack_valid_d = 1'b1;
			stack_pc_d    = exec_pc; // RULE5 RULE9 RULE10
		end else if (vector_bus_error) begin
			stack_valid_d = 1'b1;
			stack_pc_d    = preempted_pc; // RULE15
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb begin
		// Idle cycles read zero so stale data never lingers
		rdata_d = RST_ZERO;
		if (reg_read) begin
			unique case (reg_addr)
				OFS_PEND_FORCE: rdata_d[IRQ_COUNT-1:0] = irq_pending_in; // RULE2
				OFS_USAGE:      rdata_d[15:0] = usage_q;
				OFS_HARD:       rdata_d = hard_q;
				OFS_CONFIG:     rdata_d = config_q;
				OFS_IRQ_STAT:   rdata_d[IS_WIDTH-1:0] = istat_q;
				OFS_IRQ_MASK:   rdata_d[IS_WIDTH-1:0] = imask_q;
				default:        rdata_d = RST_ZERO;
			endcase
		end
	end

	// Register everything
	always_ff @(posedge clock) begin
		// Synchronous reset clears every flag, setting and output
		if (srst) begin
			pend_set_q    <= '0;
			usage_q       <= 16'h0000;
			hard_q        <= RST_ZERO;
			config_q      <= RST_ZERO;
			istat_q       <= '0;
			imask_q       <= '0;
			rdata_q       <= RST_ZERO;
			stack_valid_q <= 1'b0;
			stack_pc_q    <= RST_ZERO;
			irq_q         <= 1'b0;
		end else begin
			pend_set_q    <= pend_set_d;
			usage_q       <= usage_d;
			hard_q        <= hard_d;
			config_q      <= config_d;
			istat_q       <= istat_d;
			imask_q       <= imask_d;
			rdata_q       <= rdata_d;
			stack_valid_q <= stack_valid_d;
			stack_pc_q    <= stack_pc_d;
			irq_q         <= irq_d;
		end
	end

	// Every output comes straight from a flip-flop
	assign reg_rdata      = rdata_q;
	assign pend_set_pulse = pend_set_q;
	assign stack_valid    = stack_valid_q;
	assign stack_pc       = stack_pc_q;
	assign irq            = irq_q;

	// Checks, one property per guarded behaviour

	// Divide by zero ignored while its trap is off
	zero_div_trap_a: assert property (@(posedge clock) disable iff (srst) // RULE4
		exec_valid && divide_op && divisor_zero && !config_q[CFG_ZERO_DIV_TRAP]
		&& !usage_q[UF_ZERO_DIV] && !wr_cfg |=> !usage_q[UF_ZERO_DIV])
		else $error("zero divide flag set with trap off");

	// Trapped divide by zero records flag and divide address
	zero_div_set_a: assert property (@(posedge clock) disable iff (srst) // RULE4 RULE5
		exec_valid && divide_op && divisor_zero && config_q[CFG_ZERO_DIV_TRAP]
		|=> usage_q[UF_ZERO_DIV] && stack_pc == $past(exec_pc))
		else $error("zero divide fault not recorded");

	// Unaligned multiple and double transfers fault whatever the trap enable
	misalign_multi_a: assert property (@(posedge clock) disable iff (srst) // RULE7
		exec_valid && unaligned_access && multi_or_double_op
		|=> usage_q[UF_MISALIGN])
		else $error("multi transfer misalign not raised");

	// Single unaligned access faults with the trap on
	misalign_trap_a: assert property (@(posedge clock) disable iff (srst) // RULE6
		exec_valid && unaligned_access && config_q[CFG_MISALIGN_TRAP]
		|=> usage_q[UF_MISALIGN])
		else $error("misalign flag not set");

	// Single unaligned access passes quietly with the trap off
	misalign_off_a: assert property (@(posedge clock) disable iff (srst) // RULE6
		exec_valid && unaligned_access && !multi_or_double_op
		&& !config_q[CFG_MISALIGN_TRAP] && !usage_q[UF_MISALIGN]
		|=> !usage_q[UF_MISALIGN])
		else $error("misalign flag set with trap off");

	// Coprocessor access always faults
	no_coproc_a: assert property (@(posedge clock) disable iff (srst) // RULE8
		exec_valid && coproc_access |=> usage_q[UF_NO_COPROC])
		else $error("coprocessor flag not set");

	// Bad exception return records flag and offending address
	bad_pc_a: assert property (@(posedge clock) disable iff (srst) // RULE9
		exec_valid && bad_return_load
		|=> usage_q[UF_PC] && stack_pc == $past(exec_pc))
		else $error("bad pc load not recorded");

	// Undefined opcode outranks execution-state misuse
	state_undef_a: assert property (@(posedge clock) disable iff (srst) // RULE11 RULE17
		exec_valid && exec_status_misuse && undefined_opcode && !usage_q[UF_STATE]
		|=> !usage_q[UF_STATE] && usage_q[UF_UNDEF])
		else $error("state flag set by undefined opcode");

	// Execution-state misuse on a defined opcode
	state_set_a: assert property (@(posedge clock) disable iff (srst) // RULE10
		exec_valid && exec_status_misuse && !undefined_opcode
		|=> usage_q[UF_STATE])
		else $error("state flag not set");

	// Usage flag survives anything but a write of 1
	usage_sticky_a: assert property (@(posedge clock) disable iff (srst) // RULE18
		usage_q[UF_NO_COPROC] && !(wr_usage && reg_wdata[UF_NO_COPROC])
		|=> usage_q[UF_NO_COPROC])
		else $error("usage flag lost");

	// Write of 1 clears a usage flag when no new fault arrives
	usage_clear_a: assert property (@(posedge clock) disable iff (srst) // RULE18
		wr_usage && reg_wdata[UF_UNDEF] && !(exec_valid && undefined_opcode)
		|=> !usage_q[UF_UNDEF])
		else $error("usage flag not cleared");

	// Forced flag survives anything but a write of 1
	hard_sticky_a: assert property (@(posedge clock) disable iff (srst) // RULE12
		hard_q[HF_FORCED] && !(wr_hard && reg_wdata[HF_FORCED])
		|=> hard_q[HF_FORCED])
		else $error("forced flag lost");

	// Vector flag survives anything but a write of 1
	vector_sticky_a: assert property (@(posedge clock) disable iff (srst) // RULE12
		hard_q[HF_VECTOR] && !(wr_hard && reg_wdata[HF_VECTOR])
		|=> hard_q[HF_VECTOR])
		else $error("vector flag lost");

	// Write of 1 clears the vector flag when no bus error arrives
	hard_clear_a: assert property (@(posedge clock) disable iff (srst) // RULE12
		wr_hard && reg_wdata[HF_VECTOR] && !vector_bus_error
		|=> !hard_q[HF_VECTOR])
		else $error("vector flag not cleared");

	// Escalation always lands in the forced flag
	forced_set_a: assert property (@(posedge clock) disable iff (srst) // RULE14
		escalate_fault |=> hard_q[HF_FORCED])
		else $error("forced flag not set");

	// Vector fetch error stacks the preempted address
	vector_set_a: assert property (@(posedge clock) disable iff (srst) // RULE15
		vector_bus_error && !(|uf_set)
		|=> hard_q[HF_VECTOR] && stack_pc == $past(preempted_pc))
		else $error("vector fault not recorded");

	// Stack strobe only follows a recorded fault
	stack_pulse_a: assert property (@(posedge clock) disable iff (srst) // RULE5
		!(|uf_set) && !vector_bus_error |=> !stack_valid)
		else $error("stack strobe without fault");

	// Pending-force write becomes a one-cycle pulse
	pend_force_a: assert property (@(posedge clock) disable iff (srst) // RULE1 RULE3
		reg_write && reg_addr == OFS_PEND_FORCE
		|=> pend_set_pulse == $past(reg_wdata[IRQ_COUNT-1:0]))
		else $error("pending force pulse wrong");

	// No pulse without a pending-force write
	pend_idle_a: assert property (@(posedge clock) disable iff (srst) // RULE1
		!wr_pend |=> pend_set_pulse == '0)
		else $error("pending force pulse without write");

	// Pending read reflects the controller state
	pend_read_a: assert property (@(posedge clock) disable iff (srst) // RULE2
		reg_read && reg_addr == OFS_PEND_FORCE
		|=> reg_rdata[IRQ_COUNT-1:0] == $past(irq_pending_in))
		else $error("pending read wrong");

	// Read data stands only after a read strobe
	read_idle_a: assert property (@(posedge clock) disable iff (srst)
		!reg_read |=> reg_rdata == RST_ZERO)
		else $error("read data outside read cycle");

	// Status read drops the interrupt when nothing new arrives
	irq_clear_a: assert property (@(posedge clock) disable iff (srst)
		rd_stat && !(|uf_set) && !(|hf_set) |=> !irq)
		else $error("interrupt held after status read");

	// Reset empties the usage and hard flags and quiets irq and stack_valid
	reset_clear_a: assert property (@(posedge clock) // RULE12 RULE18
		srst |=> usage_q == 16'h0000 && hard_q == RST_ZERO && !irq && !stack_valid)
		else $error("state left after reset");

	// Main scenarios seen
	usage_clear_c: cover property (@(posedge clock) disable iff (srst)
		usage_q[UF_NO_COPROC] ##1 wr_usage ##1 !usage_q[UF_NO_COPROC]);
	hard_irq_c: cover property (@(posedge clock) disable iff (srst)
		escalate_fault ##1 hard_q[HF_FORCED] ##[1:3] irq);
	div_trap_c: cover property (@(posedge clock) disable iff (srst)
		wr_cfg ##[1:4] (exec_valid && divide_op && divisor_zero));
	pend_force_c: cover property (@(posedge clock) disable iff (srst)
		wr_pend ##1 (pend_set_pulse != '0));
	vector_stack_c: cover property (@(posedge clock) disable iff (srst)
		vector_bus_error ##1 stack_valid);
endmodule : fault_status_unit

// *** dv/core_side_model.sv ***
/*
 * Interrupt controller side of the pending-force port: keeps the
 * pending state that the block reads back. Assumes the same clock.
 */
`timescale 1ns/1ps
module core_side_model #(
	parameter int N = 32
) (
	input  wire logic         clock,
	input  wire logic         srst,
	input  wire logic [N-1:0] set_pulse,
	output logic      [N-1:0] pending_q
);
	logic [N-1:0] pending_d;
	// Pending only ever set here; the bench never takes interrupts
	always_comb pending_d = pending_q | set_pulse;
	always_ff @(posedge clock) pending_q <= srst ? '0 : pending_d;
endmodule : core_side_model

// *** dv/tb_fault_status_unit.sv ***
/*
 * Bench for the fault status block: register tasks, fault pulses,
 * a pending-state model. Assumes read data one cycle after the strobe.
 */
`timescale 1ns/1ps
module tb_fault_status_unit;
	import fault_status_pkg::*;
	logic        clock = 0;
	logic        srst = 1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 0;
	logic        reg_read = 0;
	logic [31:0] reg_rdata, pend, pulse, exec_pc = 32'h0, stack_pc;
	logic [9:0]  f = 10'h000;
	logic        exec_valid = 0;
	logic        stack_valid, irq;
	logic [31:0] ppc = 32'h0;
	int          n_fail = 0;
	int          comparisons = 0;
	always #12.5 clock = ~clock;
	fault_status_unit fault_status_unit_i (.clock(clock), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .irq_pending_in(pend),
		.pend_set_pulse(pulse), .exec_valid(exec_valid), .exec_pc(exec_pc),
		.divide_op(f[0]), .divisor_zero(f[1]), .unaligned_access(f[2]),
		.multi_or_double_op(f[3]), .coproc_access(f[4]), .undefined_opcode(f[5]),
		.exec_status_misuse(f[6]), .bad_return_load(f[7]), .escalate_fault(f[8]),
		.vector_bus_error(f[9]), .preempted_pc(ppc), .stack_valid(stack_valid),
		.stack_pc(stack_pc), .irq(irq));
	core_side_model core_side_model_i (.clock(clock), .srst(srst),
		.set_pulse(pulse), .pending_q(pend));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge clock);
		reg_write <= 0;
	endtask : wr
	// Data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clock);
		reg_read <= 0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask : rd
	// One-cycle fault pulse; s says whether an address must be stacked
	task automatic ev(input logic [9:0] c, input logic [31:0] pc, input logic s);
		@(posedge clock);
		f          <= c;
		// Vector errors stack the preempted address, all else the executing one
		exec_pc    <= c[9] ? ~pc : pc;
		ppc        <= c[9] ? pc : ~pc;
		exec_valid <= 1;
		@(posedge clock);
		f          <= 10'h000;
		exec_valid <= 0;
		#1;
		chk("stack_valid", {31'h0, stack_valid}, {31'h0, s});
		if (s) chk("stack_pc", stack_pc, pc);
	endtask : ev
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	// Watchdog well beyond the 125 or so cycles the tests need
	initial begin
		#100us;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge clock);
		srst <= 0;
		rd(OFS_USAGE, 32'h0);
		rd(OFS_HARD, 32'h0);
		rd(OFS_PEND_FORCE, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0);
		wr(OFS_PEND_FORCE, 32'h0000_00A5);
		#1 chk("pulse", pulse, 32'h0000_00A5);
		@(posedge clock) #1 chk("pulse", pulse, 32'h0);
		rd(OFS_PEND_FORCE, 32'h0000_00A5);
		wr(OFS_PEND_FORCE, 32'h0);
		wr(OFS_PEND_FORCE, 32'h8000_0001);
		rd(OFS_PEND_FORCE, 32'h8000_00A5);
		$display("test pending done");
		wr(OFS_CONFIG, 32'h0);
		ev(10'h003, 32'h100, 0);
		ev(10'h004, 32'h104, 0);
		rd(OFS_USAGE, 32'h0);
		ev(10'h00C, 32'h108, 1);
		rd(OFS_USAGE, 32'h100);
		wr(OFS_USAGE, 32'h0);
		rd(OFS_USAGE, 32'h100);
		wr(OFS_USAGE, 32'h100);
		rd(OFS_USAGE, 32'h0);
		wr(OFS_CONFIG, 32'h18);
		ev(10'h004, 32'h10C, 1);
		ev(10'h003, 32'h2000, 1);
		ev(10'h010, 32'h114, 1);
		ev(10'h080, 32'h118, 1);
		ev(10'h060, 32'h11C, 1);
		rd(OFS_USAGE, 32'h30D);
		ev(10'h040, 32'h120, 1);
		rd(OFS_USAGE, 32'h30F);
		rd(OFS_CONFIG, 32'h18);
		wr(OFS_USAGE, 32'hFFFF);
		rd(OFS_USAGE, 32'h0);
		$display("test usage done");
		ev(10'h100, 32'h200, 0);
		rd(OFS_HARD, 32'h4000_0000);
		rd(OFS_USAGE, 32'h0);
		ev(10'h200, 32'h3000, 1);
		rd(OFS_HARD, 32'h4000_0002);
		wr(OFS_HARD, 32'h0);
		rd(OFS_HARD, 32'h4000_0002);
		wr(OFS_HARD, 32'h0000_0002);
		rd(OFS_HARD, 32'h4000_0000);
		wr(OFS_HARD, 32'h4000_0000);
		rd(OFS_HARD, 32'h0);
		$display("test hard done");
		// Status reads clear, so the old usage and hard events go first
		wr(OFS_IRQ_MASK, 32'h1);
		rd(OFS_IRQ_STAT, 32'h3);
		#1 chk("irq", {31'h0, irq}, 32'h0);
		ev(10'h010, 32'h124, 1);
		#1 chk("irq", {31'h0, irq}, 32'h1);
		rd(OFS_IRQ_STAT, 32'h1);
		#25 chk("irq", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0);
		ev(10'h010, 32'h128, 1);
		#25 chk("irq", {31'h0, irq}, 32'h0);
		rd(OFS_IRQ_STAT, 32'h1);
		wr(OFS_USAGE, 32'hFFFF);
		wr(OFS_IRQ_MASK, 32'h2);
		ev(10'h100, 32'h12C, 0);
		#1 chk("irq", {31'h0, irq}, 32'h1);
		rd(OFS_IRQ_STAT, 32'h2);
		$display("test irq done");
		// Mid-run reset must empty the sticky flags
		ev(10'h010, 32'h130, 1);
		@(posedge clock) srst <= 1;
		repeat (2) @(posedge clock);
		srst <= 0;
		rd(OFS_HARD, 32'h0);
		rd(OFS_USAGE, 32'h0);
		$display("test reset done");
		end_sim();
	end
endmodule : tb_fault_status_unit
